/* lmem_pkg.sv */
// shared constants for the local-memory control strobes
package lmem_pkg;
    // memory cycle split into sixteenths
    localparam int unsigned CYCLE_TICKS    = 16;
    localparam logic [3:0]  SELECT_TICKS   = 4'h5;  // first 5/16ths: chip select
    localparam logic [3:0]  A13_START_TICK = 4'h4;  // final three-fourths: 12 of 16
    localparam logic [3:0]  LAST_TICK      = 4'hF;
    localparam logic [3:0]  WRITE_START    = 4'h5;  // strobe after address phase
    localparam logic [3:0]  WRITE_END      = 4'hE;  // released before data changes
    localparam int unsigned ADDR_W         = 21;
    localparam int unsigned A13_POS        = 13;
    localparam logic [20:0] ROM0_LO        = 21'h00_0010;
    localparam logic [20:0] ROM0_HI        = 21'h00_FFFF;
    localparam logic [20:0] ROM1_LO        = 21'h1F_0000;
    localparam logic [20:0] ROM1_HI        = 21'h1F_FFFF;
    localparam logic        RESET_OUT_IDLE = 1'b1;
    localparam logic        STROBE_IDLE    = 1'b1;
endpackage

/* lmem_strobes.sv */
// local-memory reset, rom select and write strobe outputs
module lmem_strobes (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        adapter_reset_bit_i,
    input  wire logic                        system_reset_in_i,
    input  wire logic                        cycle_start_i,
    input  wire logic                        cycle_write_i,
    input  wire logic                        code_in_ram_i,
    input  wire logic                        burn_in_access_i,
    input  wire logic [lmem_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [7:0]                  wdata_high_i,
    input  wire logic [7:0]                  wdata_low_i,
    output logic                             local_bus_reset_out_o,
    output logic                             rom_select_n_o,
    output logic                             address_latch_strobe_o,
    output logic                             write_strobe_n_o,
    output logic [7:0]                       data_bus_high_o,
    output logic [7:0]                       data_bus_low_o,
    output logic                             data_drive_o,
    output logic                             burnin_rom_select_o,
    output logic                             ext_addr_bit0_o,
    output logic                             ext_addr_bit2_o,
    output logic                             cycle_busy_o
);
    import lmem_pkg::*;

    typedef enum logic {IDLE, ACTIVE} cyc_state_t;

    cyc_state_t              state;
    cyc_state_t              next_state;
    logic [3:0]              tick;
    logic [3:0]              next_tick;
    logic [ADDR_W-1:0]       addr;
    logic [ADDR_W-1:0]       next_addr;
    logic                    wr;
    logic                    next_wr;
    logic                    burn_in_address;
    logic                    next_bia;
    logic [7:0]              dh;
    logic [7:0]              next_dh;
    logic [7:0]              dl;
    logic [7:0]              next_dl;
    logic                    rom_hit;
    logic                    next_reset_out;
    logic                    next_rom_n;
    logic                    next_ale;
    logic                    next_wr_n;
    logic                    next_drive;
    logic                    next_bia_sel;
    logic                    next_x0;
    logic                    next_x2;
    logic                    ntick_valid;

    rom_range_decode u_dec (
        .addr_i        (addr),
        .read_i        (!wr),
        .code_in_ram_i (code_in_ram_i),
        .rom_hit_o     (rom_hit)
    );

    // cycle sequencer: latches the request, then counts sixteen ticks
    always_comb begin
        next_state = state;
        next_tick  = tick;
        next_addr  = addr;
        next_wr    = wr;
        next_bia   = burn_in_address;
        next_dh    = dh;
        next_dl    = dl;
        case (state)
            IDLE: begin
                if (cycle_start_i) begin
                    next_state = ACTIVE;
                    next_tick  = 4'h0;
                    next_addr  = addr_i;
                    next_wr    = cycle_write_i;
                    next_bia   = burn_in_access_i;
                    next_dh    = wdata_high_i;
                    next_dl    = wdata_low_i;
                end
            end
            ACTIVE: begin
                next_tick = tick + 4'h1;
                if (tick == LAST_TICK) begin
                    next_state = IDLE;
                    next_tick  = 4'h0;
                end
            end
            default: begin
                next_state = IDLE;
                next_tick  = 4'h0;
            end
        endcase
        ntick_valid = (next_state == ACTIVE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state        <= IDLE;
            tick         <= 4'h0;
            addr         <= '0;
            wr           <= 1'b0;
            burn_in_address          <= 1'b0;
            dh           <= 8'h00;
            dl           <= 8'h00;
            cycle_busy_o <= 1'b0;
        end else begin
            state        <= next_state;
            tick         <= next_tick;
            addr         <= next_addr;
            wr           <= next_wr;
            burn_in_address          <= next_bia;
            dh           <= next_dh;
            dl           <= next_dl;
            cycle_busy_o <= ntick_valid;
        end
    end

    // reset to external glue: held low while either source is active
    always_comb begin
        next_reset_out = !RESET_OUT_IDLE;
        if (!adapter_reset_bit_i && !system_reset_in_i) begin
            next_reset_out = RESET_OUT_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            local_bus_reset_out_o <= !RESET_OUT_IDLE;
        end else begin
            local_bus_reset_out_o <= next_reset_out;
        end
    end

    // early part: chip select; late part: address bit for burn-in rom
    always_comb begin
        next_rom_n = 1'b1;
        // tick 0: address still entering the decoder, select held off
        if (ntick_valid && (next_tick != 4'h0) && (next_tick < SELECT_TICKS)) begin
            next_rom_n = !rom_hit;
        end
        // windows overlap at tick 4; the address bit wins there
        if (ntick_valid && (next_tick >= A13_START_TICK)) begin
            next_rom_n = next_addr[A13_POS];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rom_select_n_o <= 1'b1;
        end else begin
            rom_select_n_o <= next_rom_n;
        end
    end

    // latch strobe over the select window so glue can hold the select
    always_comb begin
        next_ale = ntick_valid && (next_tick >= 4'h1) && (next_tick < A13_START_TICK);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            address_latch_strobe_o <= 1'b0;
        end else begin
            address_latch_strobe_o <= next_ale;
        end
    end

    // write strobe and data bus
    always_comb begin
        next_wr_n = STROBE_IDLE;
        if (ntick_valid && next_wr && (next_tick >= WRITE_START) && (next_tick <= WRITE_END)) begin
            next_wr_n = !STROBE_IDLE;
        end
        // data driven from tick 1, four ticks before the strobe, until one tick after it so both edges see stable data
        next_drive = ntick_valid && next_wr && (next_tick >= 4'h1);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_strobe_n_o <= STROBE_IDLE;
            data_bus_high_o  <= 8'h00;
            data_bus_low_o   <= 8'h00;
            data_drive_o     <= 1'b0;
        end else begin
            write_strobe_n_o <= next_wr_n;
            data_bus_high_o  <= next_dh;
            data_bus_low_o   <= next_dl;
            data_drive_o     <= next_drive;
        end
    end

    // burn-in rom interface: select and ext address bits for the whole cycle
    always_comb begin
        next_bia_sel = ntick_valid && next_bia;
        next_x0      = ntick_valid && next_addr[0];
        next_x2      = ntick_valid && next_addr[2];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            burnin_rom_select_o <= 1'b0;
            ext_addr_bit0_o     <= 1'b0;
            ext_addr_bit2_o     <= 1'b0;
        end else begin
            burnin_rom_select_o <= next_bia_sel;
            ext_addr_bit0_o     <= next_x0;
            ext_addr_bit2_o     <= next_x2;
        end
    end
endmodule

/* lmem_strobes_checker.sv */
// concurrent checks on the local-memory strobe outputs
module lmem_strobes_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       adapter_reset_bit_i,
    input wire logic       system_reset_in_i,
    input wire logic       cycle_start_i,
    input wire logic       local_bus_reset_out_o,
    input wire logic       rom_select_n_o,
    input wire logic       address_latch_strobe_o,
    input wire logic       write_strobe_n_o,
    input wire logic [7:0] data_bus_high_o,
    input wire logic [7:0] data_bus_low_o,
    input wire logic       data_drive_o,
    input wire logic       cycle_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rst; !$past(rst_i) |-> local_bus_reset_out_o == !($past(adapter_reset_bit_i) || $past(system_reset_in_i)); endproperty
    a_rst: assert property (p_rst) else $error("reset out wrong");
    property p_ale; $rose(address_latch_strobe_o) |-> address_latch_strobe_o[*3] ##1 !address_latch_strobe_o; endproperty
    a_ale: assert property (p_ale) else $error("select window wrong");
    property p_start; cycle_start_i && !cycle_busy_o |=> !address_latch_strobe_o ##1 address_latch_strobe_o; endproperty
    a_start: assert property (p_start) else $error("select phase late");
    property p_wrom; address_latch_strobe_o && data_drive_o |-> rom_select_n_o; endproperty
    a_wrom: assert property (p_wrom) else $error("rom selected on write");
    property p_only; !write_strobe_n_o |-> data_drive_o; endproperty
    a_only: assert property (p_only) else $error("strobe outside write");
    property p_win; $rose(address_latch_strobe_o) && data_drive_o |-> write_strobe_n_o[*4] ##1 !write_strobe_n_o[*8]
        ##1 !write_strobe_n_o[*2] ##1 write_strobe_n_o; endproperty
    a_win: assert property (p_win) else $error("strobe window wrong");
    property p_data; !write_strobe_n_o || $rose(write_strobe_n_o) |-> $stable(data_bus_high_o) && $stable(data_bus_low_o); endproperty
    a_data: assert property (p_data) else $error("data moved under strobe");
    property p_busy; cycle_start_i && !cycle_busy_o |=> cycle_busy_o ##15 cycle_busy_o ##1 !cycle_busy_o; endproperty
    a_busy: assert property (p_busy) else $error("cycle length wrong");
endmodule
bind lmem_strobes lmem_strobes_checker i_lmem_strobes_checker (.*);

/* local_memory_rom_select_strobes_bench.sv */
// testbench for the local-memory strobes
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module local_memory_rom_select_strobes_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, ars = 0, srs = 0, start = 0, wr = 0, cir = 0, burn_in_address = 0;
    logic [20:0] addr = '0;
    logic [15:0] wd = '0, dram, sram;
    logic rst_out, rom_n, ale, wr_n, drive, bsel, busy, rom_cs_n, x0, x2;
    logic [7:0] dh, dl;
    int failures = 0, checks = 0;
    always #25 clk_i = ~clk_i;
    lmem_strobes i_lmem_strobes (.clk_i, .rst_i, .adapter_reset_bit_i(ars), .system_reset_in_i(srs),
        .cycle_start_i(start), .cycle_write_i(wr), .code_in_ram_i(cir), .burn_in_access_i(burn_in_address), .addr_i(addr),
        .wdata_high_i(wd[15:8]), .wdata_low_i(wd[7:0]), .local_bus_reset_out_o(rst_out), .rom_select_n_o(rom_n),
        .address_latch_strobe_o(ale), .write_strobe_n_o(wr_n), .data_bus_high_o(dh), .data_bus_low_o(dl),
        .data_drive_o(drive), .burnin_rom_select_o(bsel), .ext_addr_bit0_o(x0), .ext_addr_bit2_o(x2),
        .cycle_busy_o(busy));
    mem_partner i_mem_partner (.clk_i, .wr_n_i(wr_n), .ale_i(ale), .rom_n_i(rom_n), .data_i({dh, dl}),
        .dram_o(dram), .sram_o(sram), .rom_cs_n_o(rom_cs_n));
    task automatic tally_and_finish;
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one memory cycle; e early select, l late select, s burn-in select and ext bits 2, 0, n strobe-low ticks
    task automatic run(input logic w, c, b, input logic [20:0] a, output logic e, l, output logic [2:0] s,
                       output int n);
        for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk_i);
        if (busy !== 1'b0) begin failures++; tally_and_finish; end
        {start, wr, cir, burn_in_address} = {1'b1, w, c, b};
        addr = a;
        wd = {a[7:0], ~a[7:0]};
        @(negedge clk_i);
        start = 0;
        n = 0;
        for (int t = 1; t < lmem_pkg::CYCLE_TICKS; t++) begin
            @(negedge clk_i);
            if (t == 1) begin e = rom_n; s = {bsel, x2, x0}; end
            if (t == 4) l = rom_n;
            n += (wr_n === 1'b0);
        end
    endtask
    task automatic t_reset;
        for (int k = 0; k < 4; k++) begin
            {ars, srs} = k[1:0];
            @(negedge clk_i);
            `CHK(rst_out, k == 0)
        end
        {ars, srs} = 2'b00;
    endtask
    task automatic t_rom_reads;
        logic [20:0] tbl[7] = '{21'h00_0010, 21'h00_000F, 21'h00_FFFF, 21'h01_0000, 21'h1F_0000, 21'h1E_FFFF, 21'h1F_FFFF};
        logic e, l;
        logic [2:0] s;
        int n;
        for (int i = 0; i < 7; i++) begin
            run(0, 0, 0, tbl[i], e, l, s, n);
            `CHK(e, i[0])
            `CHK(l, tbl[i][13])
            `CHK(s, {1'b0, tbl[i][2], tbl[i][0]})
            `CHK(rom_cs_n, i[0])
        end
    endtask
    task automatic t_write_and_ram;
        logic e, l;
        logic [2:0] s;
        int n;
        run(1, 0, 1, 21'h1F_2000, e, l, s, n);
        `CHK(e, 1'b1)
        `CHK(n, 10)
        `CHK(dram, 16'h00FF)
        `CHK(sram, 16'h00FF)
        `CHK(s, 3'b100)
        `CHK(l, 1'b1)
        run(0, 1, 0, 21'h1F_0000, e, l, s, n);
        `CHK(e, 1'b1)
        `CHK(n, 0)
        `CHK(rom_cs_n, 1'b1)
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 0;
        t_reset;
        t_rom_reads;
        t_write_and_ram;
        tally_and_finish;
    end
endmodule

/* mem_partner.sv */
// external memory and glue latch model
module mem_partner (
    input  wire logic        clk_i,
    input  wire logic        wr_n_i,
    input  wire logic        ale_i,
    input  wire logic        rom_n_i,
    input  wire logic [15:0] data_i,
    output logic [15:0]      dram_o,
    output logic [15:0]      sram_o,
    output logic             rom_cs_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(negedge wr_n_i) dram_o = data_i;
    always @(posedge wr_n_i) sram_o = data_i;
    always @(posedge clk_i) if (ale_i) rom_cs_n_o <= rom_n_i;
endmodule

/* rom_range_decode.sv */
// boot rom address range decoder
module rom_range_decode (
    input  wire logic [lmem_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                        read_i,
    input  wire logic                        code_in_ram_i,
    output logic                             rom_hit_o
);
    import lmem_pkg::*;
    logic in_range;
    always_comb begin
        in_range = ((addr_i >= ROM0_LO) && (addr_i <= ROM0_HI)) ||
                   ((addr_i >= ROM1_LO) && (addr_i <= ROM1_HI));
        rom_hit_o = in_range && read_i && !code_in_ram_i;
    end
endmodule
